// file: src/lcdw_pkg.sv
package lcdw_pkg;
  localparam int COLS = 20;
  localparam int DD_DEPTH = 80;
  localparam int CG_DEPTH = 16;
  localparam int SEGS = 80;
  localparam int SEGS_PER_BYTE = 4;
  localparam logic [1:0] IM_SERIAL = 2'h0;
  localparam logic [1:0] IM_NIBBLE = 2'h1;
  localparam logic [4:0] START_SYNC = 5'h1f;
  localparam int START_RW = 2;
  localparam int START_RS = 1;
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CLEAR_CODE = 8'h20;
  localparam logic [6:0] CLEAR_LAST = 7'h4f;
  localparam logic [1:0] OP_CGADDR = 2'h1;
  localparam logic [2:0] OP_MODE = 3'h1;
  localparam logic [3:0] OP_POWER = 4'h1;
  localparam int B_ADDR = 7;
  localparam int B_SEGONLY = 4;
  localparam int B_TWO = 3;
  localparam int B_INC = 2;
  localparam int B_SLEEP = 3;
  localparam int B_STANDBY = 2;
  localparam int B_SGS = 1;
  typedef struct packed {
    logic rs;
    logic [7:0] data;
  } lcdw_word_t;
  typedef struct packed {
    logic sleep;
    logic standby;
    logic segment_scan_reverse;
    logic seg_only;
    logic two_lines;
    logic inc;
  } lcdw_cfg_t;
  localparam lcdw_cfg_t CFG_RESET = 6'h01;
  typedef enum logic [1:0] {
    SER_START = 2'b00,
    SER_BYTES = 2'b01,
    SER_IGNORE = 2'b10
  } lcdw_ser_t;
  typedef enum logic {
    EX_RUN = 1'b0,
    EX_CLEAR = 1'b1
  } lcdw_ex_t;
endpackage

// file: src/lcdw_fifo.sv
`timescale 1ns/1ns
module lcdw_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rp_reg];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : AW'(wp_reg + 1'b1);
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : AW'(rp_reg + 1'b1);
    end
    cnt_next = (AW+1)'(cnt_reg + push - pop);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end
endmodule

// file: src/lcdw_top.sv
`timescale 1ns/1ns
module lcdw_top
  import lcdw_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host pins
  input wire logic [1:0] interface_select_pins_i,
  input wire logic register_or_chip_select_i,
  input wire logic enable_or_sclk_i,
  input wire logic sdata_i,
  input wire logic [3:0] nibble_i,
  // Timing generator
  input wire logic [1:0] scan_row_i,
  input wire logic blink_phase_i,
  // Display and status
  output logic [SEGS-1:0] segment_drive_outputs_o,
  output logic [6:0] ram_pointer_o,
  output logic memory_target_select_o,
  output logic busy_o
);
  // ==========================================================
  // Pin synchronisers
  logic [8:0] pin_s1, pin_s2, pin_d;
  logic [1:0] im_s;
  logic sel_s, sel_d, sck_rise, e_fall, sda_s;
  logic [3:0] db_d;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= {interface_select_pins_i, register_or_chip_select_i,
                 enable_or_sclk_i, sdata_i, nibble_i};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  assign im_s = pin_s2[8:7];
  assign sel_s = pin_s2[6];
  assign sda_s = pin_s2[4];
  assign sel_d = pin_d[6];
  assign db_d = pin_d[3:0];
  assign sck_rise = !pin_d[5] && pin_s2[5];
  // Strobe data is taken from the stage before the falling edge for hold margin
  assign e_fall = pin_d[5] && !pin_s2[5];

  // ==========================================================
  // Link front end
  lcdw_ser_t ser_reg, ser_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, sh;
  logic rs_reg, rs_next, nib_hi_reg, nib_hi_next;
  logic [3:0] nib_reg, nib_next;
  logic push_reg, push_next;
  lcdw_word_t pw_reg, pw_next;

  always_comb begin
    ser_next = ser_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rs_next = rs_reg;
    nib_hi_next = nib_hi_reg;
    nib_next = nib_reg;
    push_next = 1'b0;
    pw_next = pw_reg;
    sh = {sh_reg[6:0], sda_s};
    if (im_s == IM_SERIAL) begin
      nib_hi_next = 1'b0;
      if (sel_s) begin
        ser_next = SER_START;
        bit_next = '0;
      end else if (sck_rise) begin
        sh_next = sh;
        bit_next = 3'(bit_reg + 3'h1);
        if (bit_reg == 3'h7) begin
          unique case (ser_reg)
            SER_START: begin
              if (sh[7:3] == START_SYNC && !sh[START_RW]) begin
                ser_next = SER_BYTES;
                rs_next = sh[START_RS];
              end else begin
                ser_next = SER_IGNORE;
              end
            end
            SER_BYTES: begin
              push_next = 1'b1;
              pw_next = '{rs: rs_reg, data: sh};
            end
            SER_IGNORE: begin
              ser_next = SER_IGNORE;
            end
            default: ser_next = SER_IGNORE;
          endcase
        end
      end
    end else begin
      ser_next = SER_START;
      bit_next = '0;
      if (im_s != IM_NIBBLE) begin
        nib_hi_next = 1'b0;
      end else if (e_fall) begin
        nib_hi_next = !nib_hi_reg;
        if (!nib_hi_reg) begin
          nib_next = db_d;
        end else begin
          push_next = 1'b1;
          pw_next = '{rs: sel_d, data: {nib_reg, db_d}};
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ser_reg <= SER_START;
      bit_reg <= '0;
      sh_reg <= '0;
      rs_reg <= 1'b0;
      nib_hi_reg <= 1'b0;
      nib_reg <= '0;
      push_reg <= 1'b0;
      pw_reg <= '0;
    end else begin
      ser_reg <= ser_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      rs_reg <= rs_next;
      nib_hi_reg <= nib_hi_next;
      nib_reg <= nib_next;
      push_reg <= push_next;
      pw_reg <= pw_next;
    end
  end

  // ==========================================================
  // Write queue
  // The host cannot be stalled, so a write arriving while full is lost
  logic fifo_in_ready, fifo_out_valid, ex_ready;
  lcdw_word_t fw;

  lcdw_fifo #(.W($bits(lcdw_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pw_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(ex_ready),
    .out_data_o(fw)
  );

  // ==========================================================
  // Command and data execution
  function automatic logic [7:0] dd_index(input logic [6:0] a);
    dd_index = {a[4:0] < 5'(COLS), 7'(int'(a[6:5]) * COLS + int'(a[4:0]))};
  endfunction

  lcdw_ex_t ex_reg, ex_next;
  lcdw_cfg_t cfg_reg, cfg_next;
  logic [6:0] ac_reg, ac_next, clr_reg, clr_next;
  logic rm_reg, rm_next, ex_pop, dd_we, cg_we;
  logic [7:0] dd_sel, wd;
  logic [7:0] dd_mem [DD_DEPTH];
  logic [4:0] cg_mem [CG_DEPTH];

  assign ex_ready = ex_reg == EX_RUN;

  always_comb begin
    ex_next = ex_reg;
    cfg_next = cfg_reg;
    ac_next = ac_reg;
    rm_next = rm_reg;
    clr_next = clr_reg;
    ex_pop = fifo_out_valid && ex_ready;
    dd_we = 1'b0;
    cg_we = 1'b0;
    dd_sel = dd_index(ac_reg);
    wd = fw.data;
    unique case (ex_reg)
      EX_RUN: begin
        if (ex_pop && fw.rs) begin
          dd_we = !rm_reg && dd_sel[7];
          cg_we = rm_reg;
          ac_next = cfg_reg.inc ? 7'(ac_reg + 7'h1) : 7'(ac_reg - 7'h1);
        end else if (ex_pop) begin
          if (fw.data == CMD_CLEAR) begin
            ex_next = EX_CLEAR;
            clr_next = '0;
            ac_next = '0;
            rm_next = 1'b0;
          end else if (fw.data[B_ADDR]) begin
            ac_next = fw.data[6:0];
            rm_next = 1'b0;
          end else if (fw.data[7:6] == OP_CGADDR) begin
            ac_next = {3'h0, fw.data[3:0]};
            rm_next = 1'b1;
          end else if (fw.data[7:5] == OP_MODE) begin
            cfg_next.seg_only = fw.data[B_SEGONLY];
            cfg_next.two_lines = fw.data[B_TWO];
            cfg_next.inc = fw.data[B_INC];
          end else if (fw.data[7:4] == OP_POWER) begin
            cfg_next.sleep = fw.data[B_SLEEP];
            cfg_next.standby = fw.data[B_STANDBY];
            cfg_next.segment_scan_reverse = fw.data[B_SGS];
          end
        end
      end
      EX_CLEAR: begin
        dd_we = 1'b1;
        dd_sel = {1'b1, clr_reg};
        wd = CLEAR_CODE;
        clr_next = 7'(clr_reg + 7'h1);
        if (clr_reg == CLEAR_LAST) begin
          ex_next = EX_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ex_reg <= EX_RUN;
      cfg_reg <= CFG_RESET;
      ac_reg <= '0;
      rm_reg <= 1'b0;
      clr_reg <= '0;
    end else begin
      ex_reg <= ex_next;
      cfg_reg <= cfg_next;
      ac_reg <= ac_next;
      rm_reg <= rm_next;
      clr_reg <= clr_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DD_DEPTH; i++) begin
        dd_mem[i] <= '0;
      end
    end else if (dd_we) begin
      dd_mem[dd_sel[6:0]] <= wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (cg_we) begin
      cg_mem[ac_reg[3:0]] <= wd[4:0];
    end
  end

  // ==========================================================
  // Segment outputs
  logic [SEGS-1:0] seg_reg, seg_next;
  logic busy_reg, seg_row;
  logic [7:0] sb;

  always_comb begin
    seg_next = '0;
    sb = '0;
    seg_row = cfg_reg.seg_only || (scan_row_i != 2'h0 &&
              !(cfg_reg.two_lines && scan_row_i == 2'h1));
    for (int k = 0; k < SEGS; k++) begin
      sb = dd_mem[int'(scan_row_i) * COLS + k / SEGS_PER_BYTE];
      if (seg_row && !cfg_reg.sleep && !cfg_reg.standby) begin
        seg_next[cfg_reg.segment_scan_reverse ? SEGS - 1 - k : k] =
          sb[2 * (k % SEGS_PER_BYTE) + 1] &&
          !(sb[2 * (k % SEGS_PER_BYTE)] && blink_phase_i);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seg_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      seg_reg <= seg_next;
      busy_reg <= !fifo_in_ready;
    end
  end

  assign segment_drive_outputs_o = seg_reg;
  assign ram_pointer_o = ac_reg;
  assign memory_target_select_o = rm_reg;
  assign busy_o = busy_reg;

  // ==========================================================
  // Assertions
  property p_blank;
    @(posedge clk_i) disable iff (!resetn_i)
      (cfg_reg.sleep || cfg_reg.standby) |=> segment_drive_outputs_o == '0;
  endproperty
  a_blank: assert property (p_blank)
    else $error("segments not blanked in sleep or standby");

  property p_order;
    @(posedge clk_i) disable iff (!resetn_i)
      (cfg_reg.seg_only && !cfg_reg.sleep && !cfg_reg.standby && scan_row_i == 2'h0
       && !blink_phase_i && dd_mem[0][1])
      |=> segment_drive_outputs_o[$past(cfg_reg.segment_scan_reverse) ? SEGS - 1 : 0];
  endproperty
  a_order: assert property (p_order)
    else $error("first segment on wrong pin");

  property p_reset;
    @(posedge clk_i) $rose(resetn_i) |-> ac_reg == '0 && cfg_reg == CFG_RESET
      && ex_reg == EX_RUN && segment_drive_outputs_o == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not initialised by reset");

  property p_mode;
    @(posedge clk_i) disable iff (!resetn_i)
      push_next |-> im_s == IM_SERIAL || im_s == IM_NIBBLE;
  endproperty
  a_mode: assert property (p_mode)
    else $error("write accepted in inhibited interface mode");

  property p_addr;
    @(posedge clk_i) disable iff (!resetn_i)
      (ex_pop && !fw.rs && fw.data[B_ADDR])
      |=> ac_reg == $past(fw.data[6:0]) && !rm_reg;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address set did not load pointer");

  property p_dwrite;
    @(posedge clk_i) disable iff (!resetn_i)
      (ex_pop && fw.rs && !rm_reg && dd_index(ac_reg) >= 8'h80)
      |=> dd_mem[$past(dd_sel[6:0])] == $past(fw.data);
  endproperty
  a_dwrite: assert property (p_dwrite)
    else $error("data write not committed to character memory");

  property p_fwrite;
    @(posedge clk_i) disable iff (!resetn_i)
      (ex_pop && fw.rs && rm_reg)
      |=> cg_mem[$past(ac_reg[3:0])] == $past(fw.data[4:0]);
  endproperty
  a_fwrite: assert property (p_fwrite)
    else $error("data write not committed to user font memory");

  property p_step;
    @(posedge clk_i) disable iff (!resetn_i)
      (ex_pop && fw.rs)
      |=> ac_reg == ($past(cfg_reg.inc) ? 7'($past(ac_reg) + 7'h1)
                                        : 7'($past(ac_reg) - 7'h1));
  endproperty
  a_step: assert property (p_step)
    else $error("pointer did not step by one");

  property p_nowait;
    @(posedge clk_i) disable iff (!resetn_i)
      (ex_pop && (fw.rs || fw.data != CMD_CLEAR)) |=> ex_reg == EX_RUN;
  endproperty
  a_nowait: assert property (p_nowait)
    else $error("non-clear command stalled execution");

  property p_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(ex_reg == EX_CLEAR) |-> ##80 ex_reg == EX_RUN;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear display length wrong");

  property p_sbit;
    @(posedge clk_i) disable iff (!resetn_i)
      (im_s == IM_SERIAL && !sel_s && sck_rise)
      |=> bit_reg == 3'($past(bit_reg) + 3'h1);
  endproperty
  a_sbit: assert property (p_sbit)
    else $error("serial bit not sampled on clock rise");

  property p_cov_serial;
    @(posedge clk_i) disable iff (!resetn_i) push_reg && im_s == IM_SERIAL;
  endproperty
  c_serial: cover property (p_cov_serial);

  property p_cov_nibble;
    @(posedge clk_i) disable iff (!resetn_i) push_reg && im_s == IM_NIBBLE;
  endproperty
  c_nibble: cover property (p_cov_nibble);

  property p_cov_full;
    @(posedge clk_i) disable iff (!resetn_i) ex_reg == EX_CLEAR && !fifo_in_ready;
  endproperty
  c_full: cover property (p_cov_full);

  property p_cov_seg;
    @(posedge clk_i) disable iff (!resetn_i) segment_drive_outputs_o != '0;
  endproperty
  c_seg: cover property (p_cov_seg);
endmodule

// file: tb/lcdw_host.sv
`timescale 1ns/1ns
// ==================================================================
// Host model: drives the serial link or the 4-bit bus, write-only
module lcdw_host
  import lcdw_pkg::*;
#(
  parameter int PH = 3,
  parameter int SCK_HALF = 4
) (
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic register_or_chip_select_o,
  output logic enable_or_sclk_o,
  output logic sdata_o,
  output logic [3:0] nibble_o
);
  // Select idles high so no frame is opened during reset
  initial begin
    register_or_chip_select_o = 1'b1;
    enable_or_sclk_o = 1'b0;
    sdata_o = 1'b0;
    nibble_o = 4'h0;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // ==================================================================
  // Serial link, 800 ns clock that stands still outside frames
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdata_o = b[i];
      step(SCK_HALF);
      enable_or_sclk_o = 1'b1;
      step(SCK_HALF);
      enable_or_sclk_o = 1'b0;
    end
  endtask

  task automatic ser_frame(input logic [7:0] start, input logic [7:0] b);
    step(1);
    register_or_chip_select_o = 1'b0;
    step(SCK_HALF);
    ser_byte(start);
    ser_byte(b);
    step(SCK_HALF);
    register_or_chip_select_o = 1'b1;
    // Released data line has no pull, so it must not keep the last bit
    sdata_o = ~sdata_o;
    step(2 * SCK_HALF);
  endtask

  // ==================================================================
  // 4-bit bus, high nibble first, taken on the enable fall
  task automatic nib(input logic rs, input logic [3:0] n);
    step(1);
    register_or_chip_select_o = rs;
    nibble_o = n;
    enable_or_sclk_o = 1'b1;
    step(PH);
    enable_or_sclk_o = 1'b0;
    step(PH - 1);
    nibble_o = ~n;
  endtask

  task automatic bus_word(input logic rs, input logic [7:0] b);
    nib(rs, b[7:4]);
    nib(rs, b[3:0]);
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import lcdw_pkg::*;
  // ==================================================================
  // Signals
  localparam logic [7:0] SB_CMD = {START_SYNC, 3'h0};
  localparam logic [7:0] SB_DATA = {START_SYNC, 3'h2};
  localparam logic [7:0] SB_READ = {START_SYNC, 3'h4};
  logic clk = 1'b0;
  logic resetn;
  logic [1:0] mode_pins;
  logic [1:0] scan_row;
  logic blink;
  logic sel;
  logic en_sclk;
  logic sdata;
  logic [3:0] nibble;
  logic [SEGS-1:0] seg;
  logic [6:0] ptr;
  logic tgt;
  logic busy;
  int errors;
  int cmp_count;

  always #50 clk = ~clk;

  // Smaller queue so that one clear can back it up within its 80 cycles
  lcdw_top #(.FIFO_DEPTH(4)) lcdw_top_inst (
    .clk_i(clk), .resetn_i(resetn), .interface_select_pins_i(mode_pins),
    .register_or_chip_select_i(sel), .enable_or_sclk_i(en_sclk), .sdata_i(sdata),
    .nibble_i(nibble), .scan_row_i(scan_row), .blink_phase_i(blink),
    .segment_drive_outputs_o(seg), .ram_pointer_o(ptr), .memory_target_select_o(tgt),
    .busy_o(busy)
  );

  lcdw_host lcdw_host_inst (
    .clk_i(clk), .register_or_chip_select_o(sel), .enable_or_sclk_o(en_sclk),
    .sdata_o(sdata), .nibble_o(nibble)
  );

  // ==================================================================
  // Checking helpers
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits settle through the pin synchronisers and the queue
  task automatic wait_ptr(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    while ({tgt, ptr} !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({72'h0, tgt, ptr}, {72'h0, exp});
    if (n >= lim)
      end_of_test();
  endtask

  task automatic wait_seg(input logic [79:0] exp);
    int n;
    n = 0;
    while (seg !== exp && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(seg, exp);
    if (n >= 20)
      end_of_test();
  endtask

  task automatic bw(input logic rs, input logic [7:0] b);
    lcdw_host_inst.bus_word(rs, b);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset();
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk(seg, 80'h0);
    chk({71'h0, tgt, ptr, busy}, 80'h0);
  endtask

  task automatic t_serial();
    lcdw_host_inst.ser_frame(SB_CMD, 8'ha5);
    wait_ptr(8'h25, 40);
    lcdw_host_inst.ser_frame(SB_DATA, 8'h55);
    wait_ptr(8'h26, 40);
    // A start byte asking for a read voids the rest of the frame
    lcdw_host_inst.ser_frame(SB_READ, 8'h81);
    repeat (20) @(negedge clk);
    chk({72'h0, tgt, ptr}, 80'h26);
  endtask

  task automatic t_bus();
    mode_pins = IM_NIBBLE;
    repeat (4) @(negedge clk);
    bw(1'b0, 8'h40);
    wait_ptr(8'h80, 20);
    bw(1'b1, 8'h11);
    wait_ptr(8'h81, 20);
    bw(1'b0, 8'h20);
    bw(1'b1, 8'h00);
    bw(1'b1, 8'h00);
    wait_ptr(8'hff, 20);
    mode_pins = 2'h2;
    repeat (4) @(negedge clk);
    bw(1'b0, 8'h85);
    repeat (20) @(negedge clk);
    chk({72'h0, tgt, ptr}, 80'hff);
    mode_pins = IM_NIBBLE;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_seg();
    bw(1'b0, 8'h34);
    bw(1'b0, 8'h80);
    bw(1'b1, 8'h02);
    wait_seg(80'h1);
    bw(1'b0, 8'h12);
    wait_seg({1'b1, 79'h0});
    bw(1'b0, 8'h10);
    bw(1'b0, 8'h80);
    bw(1'b1, 8'h03);
    blink = 1'b1;
    wait_seg(80'h0);
    blink = 1'b0;
    wait_seg(80'h1);
    bw(1'b0, 8'h18);
    wait_seg(80'h0);
    bw(1'b0, 8'h10);
    wait_seg(80'h1);
    bw(1'b0, 8'h14);
    wait_seg(80'h0);
    // Leave standby again, otherwise the mixed-mode rows below stay blank
    bw(1'b0, 8'h10);
    wait_seg(80'h1);
    bw(1'b0, 8'h24);
    scan_row = 2'h1;
    bw(1'b0, 8'ha0);
    wait_ptr(8'h20, 20);
    bw(1'b1, 8'h02);
    wait_seg(80'h1);
    bw(1'b0, 8'h2c);
    wait_seg(80'h0);
  endtask

  // Writes stack up behind a clear; the ones beyond the queue are lost
  task automatic t_queue();
    scan_row = 2'h0;
    bw(1'b0, 8'h34);
    bw(1'b0, CMD_CLEAR);
    repeat (5) bw(1'b1, 8'h00);
    chk({79'h0, busy}, 80'h1);
    bw(1'b1, 8'h00);
    wait_ptr(8'h04, 200);
    chk({79'h0, busy}, 80'h0);
    wait_seg(80'h4444_4444_4444_4444_0000);
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    resetn = 1'b0;
    mode_pins = IM_SERIAL;
    scan_row = 2'h0;
    blink = 1'b0;
    t_reset();
    t_serial();
    t_bus();
    t_seg();
    t_queue();
    end_of_test();
  end
endmodule
